//--- design/omm_pkg.sv
// shared constants and carriers for the overlay memory mapper
package omm_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int SEG_BYTES = 2048;
	localparam int SEG_SHIFT = 11;
	localparam int SEG_W = ADDR_W - SEG_SHIFT;
	localparam int NUM_SEGS = 1 << SEG_W;
	localparam int OVL_MIN_BYTES = 32768;
	localparam int OVL_MAX_BYTES = 2097152;
	localparam int OVL_BYTES = OVL_MAX_BYTES;
	localparam int OVL_WORDS = OVL_BYTES / 2;
	localparam int OVL_AW = 20;
	localparam int OVL_SEGS = OVL_BYTES / SEG_BYTES;
	localparam int OVL_SEG_W = 10;
	localparam logic [1:0] RESET_ATTR = 2'h0;
	localparam logic RESET_RUNNING = 1'b0;
	localparam logic RESET_ERROR = 1'b0;

	typedef enum logic [1:0] {
		ATTR_TARGET,
		ATTR_READ_WRITE,
		ATTR_READ_ONLY,
		ATTR_ILLEGAL
	} omm_attr_e;

	typedef enum logic [1:0] {
		STOP_NONE,
		STOP_MANUAL,
		STOP_BREAK,
		STOP_ERROR
	} omm_cause_e;

	typedef struct packed {
		logic strobe;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} omm_access_s;

	typedef struct packed {
		logic write;
		logic [SEG_W-1:0] seg;
		omm_attr_e attr;
		logic [OVL_SEG_W-1:0] bank;
	} omm_map_wr_s;
endpackage : omm_pkg

//--- design/omm_ram.sv
// overlay ram with registered read data
`timescale 1ns/10ps
module omm_ram import omm_pkg::*; (
	// clock
	input wire logic clock,
	// access
	input wire logic en,
	input wire logic we,
	input wire logic [OVL_AW-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	output logic [DATA_W-1:0] rdata
);
	logic [DATA_W-1:0] mem [OVL_WORDS];

	// no reset on the array so it maps to block ram
	always_ff @(posedge clock) begin
		if (en) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata <= mem[addr];
		end
	end
endmodule : omm_ram

//--- design/omm_mapper.sv
// overlay memory mapper: segment map, steering, run and pause control
`timescale 1ns/10ps
module omm_mapper import omm_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// emulated processor bus
	input wire omm_access_s cpu,
	output logic cpu_ack,
	output logic [DATA_W-1:0] cpu_rdata,
	// target system memory
	output omm_access_s tgt,
	input wire logic [DATA_W-1:0] tgt_rdata,
	input wire logic tgt_error,
	// emulator control path
	input wire omm_access_s ctl,
	output logic ctl_ack,
	output logic [DATA_W-1:0] ctl_rdata,
	input wire omm_map_wr_s map_wr,
	// run control
	input wire logic run_req,
	input wire logic stop_req,
	input wire logic break_en,
	input wire logic break_hit,
	output logic running,
	output logic error,
	output omm_cause_e stop_cause
);
	typedef struct packed {
		logic running;
		logic error;
		omm_cause_e cause;
		logic cpu_ack;
		logic ctl_ack;
		logic from_tgt;
		omm_access_s tgt;
	} omm_state_s;

	omm_state_s state, next_state;
	logic [1:0] rst_sync;
	logic rst_q_b;
	omm_attr_e attr [NUM_SEGS];
	logic [OVL_SEG_W-1:0] bank [NUM_SEGS];
	logic [NUM_SEGS-1:0] mapped;
	omm_attr_e cpu_attr, ctl_attr;
	logic cpu_ovl, ctl_ovl, violation, ram_en, ram_we, ctl_turn;
	logic [OVL_AW-1:0] ram_addr;
	logic [DATA_W-1:0] ram_wdata, ram_rdata;

	function automatic logic [SEG_W-1:0] seg_of(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:SEG_SHIFT];
	endfunction : seg_of

	// overlay word address: bank plus offset inside the segment
	function automatic logic [OVL_AW-1:0] ovl_addr(input logic [OVL_SEG_W-1:0] b, input logic [ADDR_W-1:0] a);
		return {b, a[SEG_SHIFT-1:1]};
	endfunction : ovl_addr

	// reset release through two flops
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_q_b = rst_sync[1];

	// cleared valid bits read back as target
	always_ff @(posedge clock or negedge rst_q_b) begin
		if (!rst_q_b) begin
			mapped <= '0;
		end else if (map_wr.write) begin
			mapped[map_wr.seg] <= (map_wr.attr != ATTR_TARGET);
		end
	end

	always_ff @(posedge clock) begin
		if (map_wr.write) begin
			attr[map_wr.seg] <= map_wr.attr;
			bank[map_wr.seg] <= map_wr.bank;
		end
	end

	assign cpu_attr = mapped[seg_of(cpu.addr)] ? attr[seg_of(cpu.addr)] : ATTR_TARGET;
	assign ctl_attr = mapped[seg_of(ctl.addr)] ? attr[seg_of(ctl.addr)] : ATTR_TARGET;

	assign cpu_ovl = state.running && cpu.strobe && (cpu_attr == ATTR_READ_WRITE ||
		(cpu_attr == ATTR_READ_ONLY && !cpu.write));

	assign violation = state.running && cpu.strobe && ((cpu_attr == ATTR_READ_ONLY && cpu.write) ||
		cpu_attr == ATTR_ILLEGAL);

	assign ctl_ovl = ctl.strobe && (ctl_attr == ATTR_READ_WRITE || ctl_attr == ATTR_READ_ONLY);
	// control path uses the ram only in pause, so the program never waits
	assign ctl_turn = !state.running && ctl_ovl;

	// single shared port, program has it outright in run mode
	always_comb begin
		ram_en = cpu_ovl || ctl_turn;
		ram_we = cpu_ovl ? cpu.write : (ctl_turn && ctl.write);
		ram_addr = cpu_ovl ? ovl_addr(bank[seg_of(cpu.addr)], cpu.addr) :
			ovl_addr(bank[seg_of(ctl.addr)], ctl.addr);
		ram_wdata = cpu_ovl ? cpu.wdata : ctl.wdata;
	end

	// overlay ram sized at the top of its range
	omm_ram u_ram (
		.clock(clock),
		.en(ram_en),
		.we(ram_we),
		.addr(ram_addr),
		.wdata(ram_wdata),
		.rdata(ram_rdata)
	);

	always_comb begin
		next_state = state;
		next_state.cpu_ack = 1'b0;
		next_state.ctl_ack = 1'b0;
		next_state.from_tgt = 1'b0;
		next_state.tgt = '0;
		if (state.running && cpu.strobe && !violation) begin
			next_state.cpu_ack = 1'b1;
			if (!cpu_ovl) begin
				// unmapped traffic goes to the target
				next_state.tgt = cpu;
				next_state.from_tgt = 1'b1;
			end
		end
		if (!state.running && ctl.strobe) begin
			next_state.ctl_ack = 1'b1;
			if (!ctl_ovl && ctl_attr == ATTR_TARGET) begin
				next_state.tgt = ctl;
				next_state.from_tgt = 1'b1;
			end
		end
		if (!state.running && run_req) begin
			next_state.running = 1'b1;
			next_state.error = 1'b0;
			next_state.cause = STOP_NONE;
		end
		// three stop causes, errors take precedence
		if (state.running) begin
			if (violation || tgt_error) begin
				next_state.running = 1'b0;
				next_state.error = 1'b1;
				next_state.cause = STOP_ERROR;
			end else if (break_en && break_hit) begin
				next_state.running = 1'b0;
				next_state.cause = STOP_BREAK;
			end else if (stop_req) begin
				next_state.running = 1'b0;
				next_state.cause = STOP_MANUAL;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_q_b) begin
		if (!rst_q_b) begin
			state <= '{running: RESET_RUNNING, error: RESET_ERROR, cause: STOP_NONE, cpu_ack: 1'b0, ctl_ack: 1'b0,
				from_tgt: 1'b0, tgt: '0};
		end else begin
			state <= next_state;
		end
	end

	assign tgt = state.tgt;
	assign cpu_ack = state.cpu_ack;
	assign ctl_ack = state.ctl_ack;
	assign cpu_rdata = state.from_tgt ? tgt_rdata : ram_rdata;
	assign ctl_rdata = state.from_tgt ? tgt_rdata : ram_rdata;
	assign running = state.running;
	assign error = state.error;
	assign stop_cause = state.cause;

	AST_RO_WRITE_HALTS: assert property (@(posedge clock) disable iff (!rst_q_b)
		running && cpu.strobe && cpu.write && cpu_attr == ATTR_READ_ONLY |=> !running && error)
		else $error("read-only write did not halt");
	AST_ILLEGAL_HALTS: assert property (@(posedge clock) disable iff (!rst_q_b)
		running && cpu.strobe && cpu_attr == ATTR_ILLEGAL |=> !running && error && stop_cause == STOP_ERROR)
		else $error("illegal access did not halt");
	AST_NO_WAIT: assert property (@(posedge clock) disable iff (!rst_q_b)
		running && cpu.strobe && cpu_attr == ATTR_READ_WRITE |=> cpu_ack)
		else $error("overlay access not acknowledged next cycle");
	AST_MAPPED_NOT_TARGET: assert property (@(posedge clock) disable iff (!rst_q_b)
		running && cpu.strobe && cpu_attr == ATTR_READ_WRITE |=> !tgt.strobe)
		else $error("mapped access reached target");
	AST_UNMAPPED_TARGET: assert property (@(posedge clock) disable iff (!rst_q_b)
		running && cpu.strobe && cpu_attr == ATTR_TARGET && !tgt_error |=> tgt.strobe && cpu_ack)
		else $error("target access not forwarded");
	AST_CTL_RO_WRITE: assert property (@(posedge clock) disable iff (!rst_q_b)
		!running && ctl.strobe && ctl.write && ctl_attr == ATTR_READ_ONLY |-> ram_en && ram_we ##1 ctl_ack)
		else $error("control write to read-only refused");
	AST_BREAK_PAUSE: assert property (@(posedge clock) disable iff (!rst_q_b)
		running && break_en && break_hit && !violation && !tgt_error |=> !running && stop_cause == STOP_BREAK)
		else $error("breakpoint did not pause");
	AST_STOP_PAUSE: assert property (@(posedge clock) disable iff (!rst_q_b)
		running && stop_req && !(break_en && break_hit) && !violation && !tgt_error
		|=> !running && stop_cause == STOP_MANUAL)
		else $error("manual stop did not pause");
	AST_RW_WRITE: assert property (@(posedge clock) disable iff (!rst_q_b)
		running && cpu.strobe && cpu.write && cpu_attr == ATTR_READ_WRITE |-> ram_en && ram_we ##1 cpu_ack)
		else $error("read/write segment refused a write");
	AST_MAP_STORE: assert property (@(posedge clock) disable iff (!rst_q_b)
		map_wr.write |=> (mapped[$past(map_wr.seg)] == ($past(map_wr.attr) != ATTR_TARGET)) &&
		(attr[$past(map_wr.seg)] == $past(map_wr.attr)))
		else $error("segment attribute not stored");
endmodule : omm_mapper

//--- tb/omm_tgt_model.sv
// target memory model behind the overlay memory mapper
`timescale 1ns/10ps
module omm_tgt_model import omm_pkg::*; (
	// clock
	input wire logic clock,
	// forwarded access and fault request
	input wire omm_access_s tgt,
	input wire logic err_req,
	// answer
	output logic [DATA_W-1:0] tgt_rdata,
	output logic tgt_error
);
	logic [DATA_W-1:0] mem [256];
	logic [DATA_W-1:0] last = 16'h0;
	// idle bus never repeats stale data, so a late sample shows up
	assign tgt_rdata = tgt.strobe ? mem[tgt.addr[8:1]] : ~last;
	assign tgt_error = err_req;
	always @(posedge clock) begin
		last <= tgt_rdata;
		if (tgt.strobe && tgt.write) begin
			mem[tgt.addr[8:1]] <= tgt.wdata;
		end
	end
endmodule : omm_tgt_model

//--- tb/tb.sv
// self-checking testbench for the overlay memory mapper
`timescale 1ns/10ps
module tb import omm_pkg::*; ;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	omm_access_s cpu = '0;
	omm_access_s ctl = '0;
	omm_access_s tgt, tg;
	omm_map_wr_s mw = '0;
	logic run_req = 1'b0, stop_req = 1'b0, break_en = 1'b0, break_hit = 1'b0, err_req = 1'b0;
	logic cpu_ack, ctl_ack, tgt_error, running, error, a;
	logic [DATA_W-1:0] cpu_rdata, ctl_rdata, tgt_rdata, d;
	omm_cause_e stop_cause;
	int err_total = 0;
	int compares = 0;

	always #5 clock = ~clock;

	omm_mapper dut (.clock(clock), .rst_b(rst_b), .cpu(cpu), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
		.tgt(tgt), .tgt_rdata(tgt_rdata), .tgt_error(tgt_error), .ctl(ctl), .ctl_ack(ctl_ack),
		.ctl_rdata(ctl_rdata), .map_wr(mw), .run_req(run_req), .stop_req(stop_req), .break_en(break_en),
		.break_hit(break_hit), .running(running), .error(error), .stop_cause(stop_cause));
	omm_tgt_model far (.clock(clock), .tgt(tgt), .err_req(err_req), .tgt_rdata(tgt_rdata), .tgt_error(tgt_error));

	task automatic chk_bit(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s", $time, what);
		end
	endtask : chk_bit

	task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s", $time, what);
		end
	endtask : chk_word

	// one access; answer sampled in the cycle after the strobe
	task automatic acc(input logic c, input logic w, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd);
		omm_access_s r;
		r = '{1'b1, w, ad, wd};
		@(negedge clock);
		if (c) ctl = r;
		else cpu = r;
		@(negedge clock);
		a = c ? ctl_ack : cpu_ack;
		d = c ? ctl_rdata : cpu_rdata;
		tg = tgt;
		cpu = '0;
		ctl = '0;
	endtask : acc

	task automatic map(input logic [SEG_W-1:0] s, input omm_attr_e at, input logic [OVL_SEG_W-1:0] b);
		@(negedge clock);
		mw = '{1'b1, s, at, b};
		@(negedge clock);
		mw = '0;
	endtask : map

	task automatic go_run;
		@(negedge clock);
		run_req = 1'b1;
		@(negedge clock);
		run_req = 1'b0;
	endtask : go_run

	task automatic t_routing;
		chk_bit(running, 1'b0, "pause after reset");
		go_run();
		acc(1'b0, 1'b1, 24'h001002, 16'h1234);
		chk_bit(a, 1'b1, "target write ack");
		chk_bit(tg.strobe & tg.write, 1'b1, "unmapped write to target");
		chk_word(tg.wdata, 16'h1234, "target write data");
		map(13'h0001, ATTR_READ_WRITE, 10'h005);
		map(13'h0002, ATTR_READ_WRITE, 10'h005);
		acc(1'b0, 1'b1, 24'h000802, 16'hbeef);
		chk_bit(a, 1'b1, "overlay write ack, no wait");
		chk_bit(tg.strobe, 1'b0, "overlay write kept off target");
		acc(1'b0, 1'b0, 24'h001002, 16'h0000);
		chk_word(d, 16'hbeef, "shared bank read");
		chk_bit(tg.strobe, 1'b0, "overlay read kept off target");
		map(13'h0002, ATTR_TARGET, 10'h000);
		acc(1'b0, 1'b0, 24'h001002, 16'h0000);
		chk_word(d, 16'h1234, "remapped to target");
		$display("routing test done");
	endtask : t_routing

	task automatic t_read_only;
		@(negedge clock);
		stop_req = 1'b1;
		@(negedge clock);
		stop_req = 1'b0;
		chk_bit(running, 1'b0, "manual stop");
		chk_word({14'h0, stop_cause}, {14'h0, STOP_MANUAL}, "manual cause");
		map(13'h0003, ATTR_READ_ONLY, 10'h007);
		acc(1'b1, 1'b1, 24'h001800, 16'h00c3);
		chk_bit(a, 1'b1, "control write to read-only");
		acc(1'b1, 1'b0, 24'h001800, 16'h0000);
		chk_word(d, 16'h00c3, "control read-back");
		go_run();
		acc(1'b0, 1'b0, 24'h001800, 16'h0000);
		chk_word(d, 16'h00c3, "read-only read");
		acc(1'b0, 1'b1, 24'h001800, 16'h0011);
		chk_bit(a | running, 1'b0, "read-only write halts");
		chk_bit(error, 1'b1, "read-only write error");
		chk_word({14'h0, stop_cause}, {14'h0, STOP_ERROR}, "error cause");
		map(13'h0004, ATTR_ILLEGAL, 10'h000);
		go_run();
		chk_bit(error, 1'b0, "error cleared by run");
		acc(1'b0, 1'b0, 24'h002000, 16'h0000);
		chk_bit(a | running, 1'b0, "illegal read halts");
		chk_bit(error, 1'b1, "illegal read error");
		acc(1'b0, 1'b0, 24'h001800, 16'h0000);
		chk_bit(a, 1'b0, "program access refused in pause");
		acc(1'b1, 1'b1, 24'h000004, 16'h5a5a);
		chk_bit(a & tg.strobe & tg.write, 1'b1, "control write to target");
		chk_word(tg.wdata, 16'h5a5a, "control target data");
		$display("protection test done");
	endtask : t_read_only

	task automatic t_stops;
		go_run();
		@(negedge clock);
		break_hit = 1'b1;
		@(negedge clock);
		chk_bit(running, 1'b1, "disabled break ignored");
		break_en = 1'b1;
		@(negedge clock);
		break_hit = 1'b0;
		chk_bit(running, 1'b0, "break stops");
		chk_word({14'h0, stop_cause}, {14'h0, STOP_BREAK}, "break cause");
		go_run();
		@(negedge clock);
		err_req = 1'b1;
		@(negedge clock);
		err_req = 1'b0;
		chk_bit(error & ~running, 1'b1, "target error stops");
		go_run();
		@(negedge clock);
		rst_b = 1'b0;
		#1;
		chk_bit(running, 1'b0, "reset stops");
		repeat (3) @(negedge clock);
		rst_b = 1'b1;
		repeat (3) @(negedge clock);
		go_run();
		acc(1'b0, 1'b0, 24'h000802, 16'h0000);
		chk_bit(tg.strobe, 1'b1, "map back to target");
		chk_word(d, 16'h1234, "target read data");
		$display("stop test done");
	endtask : t_stops

	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (3) @(negedge clock);
		rst_b = 1'b1;
		repeat (3) @(negedge clock);
		t_routing();
		t_read_only();
		t_stops();
		report_and_stop();
	end

	// tests need under a thousand cycles; this is far past that
	initial begin
		#50us;
		err_total++;
		report_and_stop();
	end
endmodule : tb
